// ### common/srp_pkg.sv
package srp_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [11:0] ADDR_FLAGS = 12'h000;
  localparam logic [11:0] ADDR_POL_BASE = 12'h100;
  localparam int POL_STRIDE_SHIFT = 5;
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_GAP = 5'h04;
  localparam logic [4:0] OFS_THRES = 5'h08;
  localparam logic [4:0] OFS_RATE = 5'h0C;
  localparam logic [4:0] OFS_FILL = 5'h10;
  // ****************************************
  // field positions
  // ****************************************
  localparam int CTRL_TYPE_LSB = 0;
  localparam int CTRL_FRAME_MODE_BIT = 8;
  localparam int CTRL_LIMIT_FRONT_BIT = 9;
  localparam int CTRL_LIMIT_HOST_BIT = 10;
  localparam int CTRL_QSEL_LSB = 16;
  localparam int FLAG_HOST_DROP_BIT = 0;
  localparam int FLAG_FRONT_DROP_BIT = 1;
  localparam int FLAG_ACTIVE_LSB = 16;
  localparam int HOST_TYPE_BIT = 7;
  localparam int EVT_STORM_DROP_BIT = 8;
  // ****************************************
  // widths and reset values
  // ****************************************
  localparam int TYPE_W = 8;
  localparam int QSEL_W = 8;
  localparam int GAP_W = 7;
  localparam int THRES_W = 6;
  localparam int RATE_W = 17;
  localparam int FILL_W = 20;
  localparam int LEN_W = 14;
  localparam int THRES_UNIT_SHIFT = 12;
  localparam logic [LEN_W-1:0] SHORT_ERR_LEN = 14'h0094;
  localparam logic [TYPE_W-1:0] TYPE_RST = 8'h00;
  localparam logic [QSEL_W-1:0] QSEL_RST = 8'h00;
  localparam logic [GAP_W-1:0] GAP_RST = 7'h00;
  localparam logic [THRES_W-1:0] THRES_RST = 6'h00;
  localparam logic [RATE_W-1:0] RATE_RST = 17'h00000;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int DRAIN_PERIOD_NS = 1000;
  localparam int DRAIN_CYCLES = (DRAIN_PERIOD_NS / CLK_PERIOD_NS < 1) ? 1 :
                                DRAIN_PERIOD_NS / CLK_PERIOD_NS;
endpackage : srp_pkg

// ### hdl/srp_storm_policer.sv
// Function
// [RULE1] 8-bit traffic type mask selects policed frames
// [RULE2] frame mode counts frames, not bytes
// [RULE3] separate enables for host and front limiting
// [RULE4] 8-bit mask selects policed host queues
// [RULE5] 7-bit overhead adjusts each frame contribution
// [RULE6] burst limit is threshold times 4K
// [RULE7] 17-bit rate sets bucket drain
// [RULE8] short errored and control frames ignored
// [RULE9] software enables via type mask and rate
// [RULE10] host frames policed when bit7 clear, queue selected
// [RULE11] sticky flag on any host-bound drop
// [RULE12] sticky flag on any front-bound drop
// [RULE13] per-policer sticky flag when active and open
// [RULE14] each drop signalled as statistics event
// [RULE15] 12-bit event mask layout to statistics
// [RULE16] closed policer discards frame to every port
// [RULE17] fill grows per frame, drains, closes above limit
// [RULE18] sticky flags cleared by writing one
//
// Local design decisions: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module srp_storm_policer #(
  parameter int NUM_POL = 8
) (
  // clock and reset
  input wire logic SYS_CLK_I,
  input wire logic SYS_RST_I,
  // ahb-lite slave
  input wire logic HSEL_I,
  input wire logic [11:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  output logic [31:0] HRDATA_O,
  // frame from classifier
  input wire logic FRM_VALID_I,
  input wire logic [13:0] FRM_LEN_I,
  input wire logic [2:0] FRM_TYPE_I,
  input wire logic FRM_ERR_I,
  input wire logic FRM_MAC_CTRL_I,
  input wire logic FRM_TO_HOST_I,
  input wire logic [2:0] FRM_HOST_QUEUE_I,
  input wire logic FRM_TO_FRONT_I,
  input wire logic [3:0] FRM_EARLY_EVENTS_I,
  input wire logic [3:0] FRM_PORT_POL_EVENTS_I,
  input wire logic [2:0] FRM_OTHER_EVENTS_I,
  // verdict to forwarding and statistics
  output logic RES_VALID_O,
  output logic RES_DROP_O,
  output logic [11:0] RES_EVENT_MASK_O
);
  // ****************************************
  // elaboration checks
  // ****************************************
  if (NUM_POL < 2 || NUM_POL > 8) begin : g_bad_num
    $error("NUM_POL must lie in 2..8");
  end

  localparam int IW = $clog2(NUM_POL);
  localparam int DW = $clog2(srp_pkg::DRAIN_CYCLES + 1);

  // ****************************************
  // ahb-lite data phase capture
  // ****************************************
  logic wr_pend_reg;
  logic [11:0] wr_addr_reg;
  logic addr_phase;
  assign addr_phase = HSEL_I && HREADY_I && HTRANS_I[1];

  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 12'h000;
    end else begin
      wr_pend_reg <= addr_phase && HWRITE_I;
      if (addr_phase) begin
        wr_addr_reg <= HADDR_I;
      end
    end
  end

  // zero wait states, always okay
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      HREADYOUT_O <= 1'b1;
      HRESP_O <= 1'b0;
    end else begin
      HREADYOUT_O <= 1'b1;
      HRESP_O <= 1'b0;
    end
  end

  logic wr_flags;
  logic wr_pol_area;
  logic [IW-1:0] wr_idx;
  logic [4:0] wr_ofs;
  assign wr_flags = wr_pend_reg && (wr_addr_reg == srp_pkg::ADDR_FLAGS);
  assign wr_pol_area = wr_pend_reg && (wr_addr_reg[11:8] == 4'h1) &&
                       (wr_addr_reg[7:srp_pkg::POL_STRIDE_SHIFT] < NUM_POL);
  assign wr_idx = wr_addr_reg[srp_pkg::POL_STRIDE_SHIFT +: IW];
  assign wr_ofs = wr_addr_reg[4:0];

  // ****************************************
  // frame qualification
  // ****************************************
  // mac never forwards these, so they never touch a bucket
  logic frm_ok;
  assign frm_ok = FRM_VALID_I && !FRM_MAC_CTRL_I &&
                  !(FRM_ERR_I && FRM_LEN_I < srp_pkg::SHORT_ERR_LEN); // [RULE8]

  // drain tick shared by all buckets
  logic [DW-1:0] drain_cnt_reg;
  logic drain_tick;
  assign drain_tick = (drain_cnt_reg == DW'(srp_pkg::DRAIN_CYCLES - 1));
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      drain_cnt_reg <= '0;
    end else if (drain_tick) begin
      drain_cnt_reg <= '0;
    end else begin
      drain_cnt_reg <= drain_cnt_reg + DW'(1);
    end
  end

  // ****************************************
  // policer bank
  // ****************************************
  logic [srp_pkg::TYPE_W-1:0] type_mask_reg [NUM_POL];
  logic [srp_pkg::QSEL_W-1:0] host_queue_select_reg [NUM_POL];
  logic [NUM_POL-1:0] count_frames_not_bytes_reg;
  logic [NUM_POL-1:0] limit_front_port_traffic_reg;
  logic [NUM_POL-1:0] limit_host_cpu_traffic_reg;
  logic [srp_pkg::GAP_W-1:0] gap_reg [NUM_POL];
  logic [srp_pkg::THRES_W-1:0] burst_capacity_reg [NUM_POL];
  logic [srp_pkg::RATE_W-1:0] rate_reg [NUM_POL];
  logic [srp_pkg::FILL_W-1:0] fill_reg [NUM_POL];
  logic [NUM_POL-1:0] pol_host_drop;
  logic [NUM_POL-1:0] pol_front_drop;
  logic [NUM_POL-1:0] pol_open_hit;

  for (genvar i = 0; i < NUM_POL; i++) begin : g_pol
    logic wr_me;
    logic applies;
    logic closed;
    logic drops;
    logic [srp_pkg::FILL_W-1:0] limit;
    logic [srp_pkg::FILL_W-1:0] add;
    logic [srp_pkg::FILL_W-1:0] after_drain;
    logic [srp_pkg::FILL_W:0] grown;
    logic signed [srp_pkg::LEN_W+1:0] len_adj;

    assign wr_me = wr_pol_area && (wr_idx == IW'(i));

    always_ff @(posedge SYS_CLK_I) begin
      if (SYS_RST_I) begin
        type_mask_reg[i] <= srp_pkg::TYPE_RST;
        host_queue_select_reg[i] <= srp_pkg::QSEL_RST;
        count_frames_not_bytes_reg[i] <= 1'b0;
        limit_front_port_traffic_reg[i] <= 1'b0;
        limit_host_cpu_traffic_reg[i] <= 1'b0;
        gap_reg[i] <= srp_pkg::GAP_RST;
        burst_capacity_reg[i] <= srp_pkg::THRES_RST;
        rate_reg[i] <= srp_pkg::RATE_RST;
      end else if (wr_me) begin
        case (wr_ofs)
          srp_pkg::OFS_CTRL: begin
            type_mask_reg[i] <=
              HWDATA_I[srp_pkg::CTRL_TYPE_LSB +: srp_pkg::TYPE_W]; // [RULE1]
            count_frames_not_bytes_reg[i] <=
              HWDATA_I[srp_pkg::CTRL_FRAME_MODE_BIT];
            limit_front_port_traffic_reg[i] <=
              HWDATA_I[srp_pkg::CTRL_LIMIT_FRONT_BIT]; // [RULE3]
            limit_host_cpu_traffic_reg[i] <=
              HWDATA_I[srp_pkg::CTRL_LIMIT_HOST_BIT]; // [RULE3]
            host_queue_select_reg[i] <=
              HWDATA_I[srp_pkg::CTRL_QSEL_LSB +: srp_pkg::QSEL_W]; // [RULE4]
          end
          srp_pkg::OFS_GAP: begin
            gap_reg[i] <= HWDATA_I[srp_pkg::GAP_W-1:0]; // [RULE5]
          end
          srp_pkg::OFS_THRES: begin
            burst_capacity_reg[i] <= HWDATA_I[srp_pkg::THRES_W-1:0]; // [RULE6]
          end
          srp_pkg::OFS_RATE: begin
            rate_reg[i] <= HWDATA_I[srp_pkg::RATE_W-1:0]; // [RULE7]
          end
          default: begin
          end
        endcase
      end
    end

    // a zero mask or zero rate leaves the policer idle [RULE9]
    assign applies = frm_ok && (rate_reg[i] != '0) &&
                     type_mask_reg[i][FRM_TYPE_I] && // [RULE1]
                     (!FRM_TO_HOST_I ||
                      (!type_mask_reg[i][srp_pkg::HOST_TYPE_BIT] && // [RULE10]
                       host_queue_select_reg[i][FRM_HOST_QUEUE_I]));

    assign limit = srp_pkg::FILL_W'(burst_capacity_reg[i]) <<
                   srp_pkg::THRES_UNIT_SHIFT; // [RULE6]
    assign closed = fill_reg[i] > limit; // [RULE17]
    assign drops = applies && closed && // [RULE3]
                   ((FRM_TO_HOST_I && limit_host_cpu_traffic_reg[i]) ||
                    (FRM_TO_FRONT_I && limit_front_port_traffic_reg[i]));
    assign pol_host_drop[i] = drops && FRM_TO_HOST_I; // [RULE11]
    assign pol_front_drop[i] = drops && FRM_TO_FRONT_I; // [RULE12]
    assign pol_open_hit[i] = applies && !closed;

    // overhead is signed so it can take bytes away as well
    assign len_adj = $signed({2'b00, FRM_LEN_I}) +
                     $signed({{(srp_pkg::LEN_W+2-srp_pkg::GAP_W)
                               {gap_reg[i][6]}}, gap_reg[i]}); // [RULE5]
    always_comb begin
      if (count_frames_not_bytes_reg[i]) begin
        add = srp_pkg::FILL_W'(1); // [RULE2]
      end else if (len_adj < 0) begin
        add = '0;
      end else begin
        add = srp_pkg::FILL_W'(len_adj[srp_pkg::LEN_W:0]); // [RULE17]
      end
    end

    assign after_drain = (!drain_tick) ? fill_reg[i] : // [RULE7]
      (fill_reg[i] > srp_pkg::FILL_W'(rate_reg[i])) ?
      fill_reg[i] - srp_pkg::FILL_W'(rate_reg[i]) : '0;
    // only open buckets take the frame
    assign grown = {1'b0, after_drain} + {1'b0, add};

    always_ff @(posedge SYS_CLK_I) begin
      if (SYS_RST_I) begin
        fill_reg[i] <= '0;
      end else if (applies && !closed) begin
        fill_reg[i] <= grown[srp_pkg::FILL_W] ? '1 :
                       grown[srp_pkg::FILL_W-1:0]; // [RULE17]
      end else begin
        fill_reg[i] <= after_drain;
      end
    end
  end

  // ****************************************
  // sticky flags
  // ****************************************
  logic host_drop_flag_reg;
  logic front_drop_flag_reg;
  logic [NUM_POL-1:0] active_open_flag_reg;

  // a new event in the clearing cycle keeps the flag set
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      host_drop_flag_reg <= 1'b0;
      front_drop_flag_reg <= 1'b0;
      active_open_flag_reg <= '0;
    end else begin
      host_drop_flag_reg <= (|pol_host_drop) || (host_drop_flag_reg &&
        !(wr_flags && HWDATA_I[srp_pkg::FLAG_HOST_DROP_BIT])); // [RULE18]
      front_drop_flag_reg <= (|pol_front_drop) || (front_drop_flag_reg &&
        !(wr_flags && HWDATA_I[srp_pkg::FLAG_FRONT_DROP_BIT])); // [RULE18]
      active_open_flag_reg <= pol_open_hit | (active_open_flag_reg &
        ~(wr_flags ? HWDATA_I[srp_pkg::FLAG_ACTIVE_LSB +: NUM_POL]
                   : NUM_POL'(0))); // [RULE13] [RULE18]
    end
  end

  // ****************************************
  // verdict and statistics events
  // ****************************************
  logic any_drop;
  assign any_drop = |(pol_host_drop | pol_front_drop);

  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      RES_VALID_O <= 1'b0;
      RES_DROP_O <= 1'b0;
      RES_EVENT_MASK_O <= 12'h000;
    end else begin
      RES_VALID_O <= FRM_VALID_I;
      // a dropped frame goes nowhere, host included
      RES_DROP_O <= FRM_VALID_I && any_drop; // [RULE16]
      RES_EVENT_MASK_O <= FRM_VALID_I ?
        {FRM_OTHER_EVENTS_I, any_drop, FRM_PORT_POL_EVENTS_I,
         FRM_EARLY_EVENTS_I} : 12'h000; // [RULE14] [RULE15]
    end
  end

  // ****************************************
  // register read
  // ****************************************
  logic [31:0] rd_data;
  logic [IW-1:0] rd_idx;
  assign rd_idx = HADDR_I[srp_pkg::POL_STRIDE_SHIFT +: IW];

  always_comb begin
    rd_data = 32'h0000_0000;
    if (HADDR_I == srp_pkg::ADDR_FLAGS) begin
      rd_data[srp_pkg::FLAG_HOST_DROP_BIT] = host_drop_flag_reg;
      rd_data[srp_pkg::FLAG_FRONT_DROP_BIT] = front_drop_flag_reg;
      rd_data[srp_pkg::FLAG_ACTIVE_LSB +: NUM_POL] = active_open_flag_reg;
    end else if (HADDR_I[11:8] == 4'h1 &&
                 HADDR_I[7:srp_pkg::POL_STRIDE_SHIFT] < NUM_POL) begin
      case (HADDR_I[4:0])
        srp_pkg::OFS_CTRL: begin
          rd_data[srp_pkg::CTRL_TYPE_LSB +: srp_pkg::TYPE_W] =
            type_mask_reg[rd_idx];
          rd_data[srp_pkg::CTRL_FRAME_MODE_BIT] =
            count_frames_not_bytes_reg[rd_idx];
          rd_data[srp_pkg::CTRL_LIMIT_FRONT_BIT] =
            limit_front_port_traffic_reg[rd_idx];
          rd_data[srp_pkg::CTRL_LIMIT_HOST_BIT] =
            limit_host_cpu_traffic_reg[rd_idx];
          rd_data[srp_pkg::CTRL_QSEL_LSB +: srp_pkg::QSEL_W] =
            host_queue_select_reg[rd_idx];
        end
        srp_pkg::OFS_GAP: rd_data[srp_pkg::GAP_W-1:0] = gap_reg[rd_idx];
        srp_pkg::OFS_THRES:
          rd_data[srp_pkg::THRES_W-1:0] = burst_capacity_reg[rd_idx];
        srp_pkg::OFS_RATE: rd_data[srp_pkg::RATE_W-1:0] = rate_reg[rd_idx];
        srp_pkg::OFS_FILL: rd_data[srp_pkg::FILL_W-1:0] = fill_reg[rd_idx];
        default: rd_data = 32'h0000_0000;
      endcase
    end
  end

  // captured in the address phase, stands through the data phase
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      HRDATA_O <= 32'h0000_0000;
    end else if (addr_phase && !HWRITE_I) begin
      HRDATA_O <= rd_data;
    end
  end
endmodule : srp_storm_policer
`default_nettype wire

// ### testbench/srp_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// verdict path checker
// ****************************************
module srp_sva (
  // clock and reset
  input wire logic SYS_CLK_I,
  input wire logic SYS_RST_I,
  // frame side
  input wire logic FRM_VALID_I,
  input wire logic [13:0] FRM_LEN_I,
  input wire logic FRM_ERR_I,
  input wire logic FRM_MAC_CTRL_I,
  input wire logic FRM_TO_HOST_I,
  input wire logic FRM_TO_FRONT_I,
  input wire logic [3:0] FRM_EARLY_EVENTS_I,
  input wire logic [3:0] FRM_PORT_POL_EVENTS_I,
  input wire logic [2:0] FRM_OTHER_EVENTS_I,
  // verdict side
  input wire logic RES_VALID_O,
  input wire logic RES_DROP_O,
  input wire logic [11:0] RES_EVENT_MASK_O
);
  default clocking @(posedge SYS_CLK_I);
  endclocking
  default disable iff (SYS_RST_I);
  sequence s_ignored;
    FRM_VALID_I && (FRM_MAC_CTRL_I || (FRM_ERR_I && FRM_LEN_I < 14'h0094));
  endsequence
  sequence s_kept;
    RES_VALID_O && !RES_DROP_O && !RES_EVENT_MASK_O[8];
  endsequence
  property p_answer;
    FRM_VALID_I |=> RES_VALID_O;
  endproperty
  property p_quiet;
    !FRM_VALID_I |=> !RES_VALID_O && !RES_DROP_O && RES_EVENT_MASK_O == 12'h000;
  endproperty
  property p_ignored;
    s_ignored |=> s_kept;
  endproperty
  property p_drop_event;
    RES_VALID_O |-> RES_EVENT_MASK_O[8] == RES_DROP_O;
  endproperty
  property p_low_bits;
    FRM_VALID_I |=> RES_EVENT_MASK_O[7:0] ==
      {$past(FRM_PORT_POL_EVENTS_I), $past(FRM_EARLY_EVENTS_I)};
  endproperty
  property p_high_bits;
    FRM_VALID_I |=> RES_EVENT_MASK_O[11:9] == $past(FRM_OTHER_EVENTS_I);
  endproperty
  property p_no_dest;
    FRM_VALID_I && !FRM_TO_HOST_I && !FRM_TO_FRONT_I |=> s_kept;
  endproperty
  property p_drop_cause;
    RES_DROP_O |-> $past(FRM_VALID_I) && !$past(FRM_MAC_CTRL_I);
  endproperty
  a_answer: assert property (p_answer) else $error("no verdict");
  a_quiet: assert property (p_quiet) else $error("stray verdict");
  a_ignored: assert property (p_ignored) else $error("ignored hit");
  a_drop_event: assert property (p_drop_event) else $error("evt");
  a_low_bits: assert property (p_low_bits) else $error("low evt");
  a_high_bits: assert property (p_high_bits) else $error("hi evt");
  a_no_dest: assert property (p_no_dest) else $error("no dest drop");
  a_drop_cause: assert property (p_drop_cause) else $error("drop");
endmodule : srp_sva
bind srp_storm_policer srp_sva u_sva (
  .SYS_CLK_I(SYS_CLK_I),
  .SYS_RST_I(SYS_RST_I),
  .FRM_VALID_I(FRM_VALID_I),
  .FRM_LEN_I(FRM_LEN_I),
  .FRM_ERR_I(FRM_ERR_I),
  .FRM_MAC_CTRL_I(FRM_MAC_CTRL_I),
  .FRM_TO_HOST_I(FRM_TO_HOST_I),
  .FRM_TO_FRONT_I(FRM_TO_FRONT_I),
  .FRM_EARLY_EVENTS_I(FRM_EARLY_EVENTS_I),
  .FRM_PORT_POL_EVENTS_I(FRM_PORT_POL_EVENTS_I),
  .FRM_OTHER_EVENTS_I(FRM_OTHER_EVENTS_I),
  .RES_VALID_O(RES_VALID_O),
  .RES_DROP_O(RES_DROP_O),
  .RES_EVENT_MASK_O(RES_EVENT_MASK_O)
);
`default_nettype wire

// ### testbench/srp_frame_src.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// classifier model
// ****************************************
module srp_frame_src (
  // clock
  input wire logic clk_i,
  // frame to policer
  output logic valid_o,
  output logic [13:0] len_o,
  output logic [2:0] type_o,
  output logic err_o,
  output logic ctl_o,
  output logic host_o,
  output logic [2:0] queue_o,
  output logic front_o,
  output logic [3:0] early_o,
  output logic [3:0] ppol_o,
  output logic [2:0] other_o
);
  initial begin
    {valid_o, len_o, type_o, err_o, ctl_o, host_o} = '0;
    {queue_o, front_o, early_o, ppol_o, other_o} = '0;
  end
  // early and port-policer event bits follow the length, other events follow the type, so every bit but early bits 0-1 and port-policer bit 0 is exercised
  task send(input logic [13:0] l, input logic [2:0] t, q,
            input logic h, f, e, c);
    @(posedge clk_i);
    valid_o <= 1'b1;
    len_o <= l;
    type_o <= t;
    err_o <= e; // only on request
    ctl_o <= c; // only on request
    host_o <= h;
    queue_o <= q;
    front_o <= f;
    early_o <= l[3:0];
    ppol_o <= l[7:4];
    other_o <= t;
  endtask : send
  // length, type, queue and early-event fields flip when idle, so stale values cannot pass for held ones
  task idle;
    @(posedge clk_i);
    valid_o <= 1'b0;
    {len_o, type_o, queue_o, early_o} <= ~{len_o, type_o, queue_o, early_o};
  endtask : idle
endmodule : srp_frame_src
`default_nettype wire

// ### testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ****************************************
  // signals
  // ****************************************
  logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hready;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, hrdata, r;
  logic hresp, fv, fe, fc, fh, ff, res_v, res_d;
  logic [13:0] fl;
  logic [2:0] ft, fq, fo;
  logic [3:0] fa, fp;
  logic [11:0] res_e;
  int fails = 0, cmp_count = 0;
  always #20 clk = ~clk;
  srp_frame_src u_src (.clk_i(clk), .valid_o(fv), .len_o(fl), .type_o(ft),
    .err_o(fe), .ctl_o(fc), .host_o(fh), .queue_o(fq), .front_o(ff),
    .early_o(fa), .ppol_o(fp), .other_o(fo));
  srp_storm_policer u_dut (.SYS_CLK_I(clk), .SYS_RST_I(rst), .HSEL_I(hsel),
    .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
    .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
    .HREADYOUT_O(hready), .HRESP_O(hresp), .HRDATA_O(hrdata),
    .FRM_VALID_I(fv), .FRM_LEN_I(fl), .FRM_TYPE_I(ft), .FRM_ERR_I(fe),
    .FRM_MAC_CTRL_I(fc), .FRM_TO_HOST_I(fh), .FRM_HOST_QUEUE_I(fq),
    .FRM_TO_FRONT_I(ff), .FRM_EARLY_EVENTS_I(fa),
    .FRM_PORT_POL_EVENTS_I(fp), .FRM_OTHER_EVENTS_I(fo),
    .RES_VALID_O(res_v), .RES_DROP_O(res_d), .RES_EVENT_MASK_O(res_e));
  // ****************************************
  // shared tasks
  // ****************************************
  task report_and_stop;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop
  task chk(input string n, input logic [31:0] e, s);
    cmp_count++;
    if (s !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, s);
      fails++;
    end
  endtask : chk
  task wait_rdy;
    for (int i = 0; i < 50; i++) begin
      @(posedge clk);
      if (hready === 1'b1) return;
    end
    fails++;
    report_and_stop();
  endtask : wait_rdy
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : bus
  task rdchk(input string n, input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(n, e, r);
  endtask : rdchk
  function automatic logic [11:0] pa(input int i, input logic [4:0] o);
    return srp_pkg::ADDR_POL_BASE + 12'(i * 32) + {7'h00, o};
  endfunction : pa
  task cfg(input int i, input logic [31:0] c, g, t, ra);
    bus(1'b1, pa(i, srp_pkg::OFS_CTRL), c);
    bus(1'b1, pa(i, srp_pkg::OFS_GAP), g);
    bus(1'b1, pa(i, srp_pkg::OFS_THRES), t);
    bus(1'b1, pa(i, srp_pkg::OFS_RATE), ra);
  endtask : cfg
  // one frame with an idle cycle behind it, verdict judged after it lands
  task frm(input logic [13:0] l, input logic [2:0] t, q,
           input logic h, f, e, c, d);
    u_src.send(l, t, q, h, f, e, c);
    u_src.idle();
    #1;
    chk("verdict", 1'b1, res_v);
    chk("drop", d, res_d);
    chk("events", {20'h0, t, d, l[7:0]}, {20'h0, res_e});
  endtask : frm
  // ****************************************
  // scenarios
  // ****************************************
  task t_reset;
    rdchk("ctrl", pa(0, srp_pkg::OFS_CTRL), 32'h0);
    rdchk("rate", pa(0, srp_pkg::OFS_RATE), 32'h0);
    rdchk("flags", srp_pkg::ADDR_FLAGS, 32'h0);
    rdchk("unmapped", 12'hFFC, 32'h0);
  endtask : t_reset
  task t_bytes;
    cfg(0, 32'h0000_0204, 32'h4, 32'h1, 32'h1);
    rdchk("ctrl", pa(0, srp_pkg::OFS_CTRL), 32'h0000_0204);
    repeat (5) frm(14'd1000, 3'd2, 3'd0, 0, 1, 0, 0, 0);
    bus(1'b0, pa(0, srp_pkg::OFS_FILL), 32'h0);
    chk("fill", 1, r <= 5020 && r >= 5015);
    frm(14'd1000, 3'd2, 3'd0, 0, 1, 0, 0, 1);
    frm(14'd64, 3'd3, 3'd0, 0, 1, 0, 0, 0);
    frm(14'd64, 3'd2, 3'd0, 0, 1, 0, 1, 0);
    frm(14'd100, 3'd2, 3'd0, 0, 1, 1, 0, 0);
    frm(14'd200, 3'd2, 3'd0, 0, 1, 1, 0, 1);
    frm(14'd64, 3'd2, 3'd0, 0, 0, 0, 0, 0);
    frm(14'd64, 3'd2, 3'd1, 1, 0, 0, 0, 0);
    rdchk("flags", srp_pkg::ADDR_FLAGS, 32'h0001_0002);
  endtask : t_bytes
  task t_host;
    bus(1'b1, pa(0, srp_pkg::OFS_CTRL), 32'h0002_0604);
    frm(14'd64, 3'd2, 3'd1, 1, 0, 0, 0, 1);
    frm(14'd64, 3'd2, 3'd2, 1, 0, 0, 0, 0);
    bus(1'b1, pa(0, srp_pkg::OFS_CTRL), 32'h0002_0684);
    frm(14'd64, 3'd2, 3'd1, 1, 0, 0, 0, 0);
    rdchk("flags", srp_pkg::ADDR_FLAGS, 32'h0001_0003);
    bus(1'b1, srp_pkg::ADDR_FLAGS, 32'hFFFF_FFFF);
    rdchk("flags", srp_pkg::ADDR_FLAGS, 32'h0);
  endtask : t_host
  task t_frames;
    cfg(1, 32'h0000_0301, 32'h0, 32'h1, 32'h1);
    frm(14'd9000, 3'd0, 3'd0, 0, 1, 0, 0, 0);
    bus(1'b0, pa(1, srp_pkg::OFS_FILL), 32'h0);
    chk("frame fill", 1, r < 2);
    rdchk("flags", srp_pkg::ADDR_FLAGS, 32'h0002_0000);
    cfg(2, 32'h0000_0210, 32'h0, 32'h0, 32'h0);
    frm(14'd9000, 3'd4, 3'd0, 0, 1, 0, 0, 0);
    rdchk("idle fill", pa(2, srp_pkg::OFS_FILL), 32'h0);
  endtask : t_frames
  // negative overhead, then exactly two drain ticks before the read
  task t_drain;
    cfg(3, 32'h0000_0220, 32'h7C, 32'h1, 32'h64);
    frm(14'd1000, 3'd5, 3'd0, 0, 1, 0, 0, 0);
    repeat (2 * srp_pkg::DRAIN_CYCLES) @(posedge clk);
    rdchk("drained fill", pa(3, srp_pkg::OFS_FILL), 32'h0000_031C);
  endtask : t_drain
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_bytes();
    t_host();
    t_frames();
    t_drain();
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
